// ==== uie_pkg.sv ====
// Package for the UART interrupt enable and receive line status block.
// Assumes an 8-bit register port with 4-bit byte addresses; no other bus.
package uie_pkg;
    localparam logic [3:0] ADDR_INT_ENABLE  = 4'h1;
    localparam logic [3:0] ADDR_INT_STATUS  = 4'h2;
    localparam logic [3:0] ADDR_FIFO_CTRL   = 4'h2;
    localparam logic [3:0] ADDR_LINE_CTRL   = 4'h3;
    localparam logic [3:0] ADDR_LINE_STATUS = 4'h5;
    localparam logic [7:0] LINE_CTRL_ENH    = 8'hBF;
    localparam logic [7:0] RST_INT_ENABLE   = 8'h00;
    localparam logic [7:0] RST_LINE_CTRL    = 8'h00;
    localparam logic [7:0] RST_ENH_CTRL     = 8'h00;
    localparam logic [7:0] RST_FIFO_CTRL    = 8'h00;
    localparam int         IE_RX     = 0;
    localparam int         IE_TX     = 1;
    localparam int         IE_LINE   = 2;
    localparam int         IE_MODEM  = 3;
    localparam int         IE_SLEEP  = 4;
    localparam int         IE_PAUSE  = 5;
    localparam int         IE_RTS    = 6;
    localparam int         IE_CTS    = 7;
    localparam int         EFC_ENH   = 4;
    localparam int         FC_EN     = 0;
    localparam int         LC_DIV    = 7;
    localparam logic [7:0] ISR_NONE  = 8'h01;
    localparam logic [5:0] ISR_LINE  = 6'h06;
    localparam logic [5:0] ISR_RXTO  = 6'h0C;
    localparam logic [5:0] ISR_RXRDY = 6'h04;
    localparam logic [5:0] ISR_TXRDY = 6'h02;
    localparam logic [5:0] ISR_MODEM = 6'h00;
    localparam logic [5:0] ISR_PAUSE = 6'h10;
    localparam logic [5:0] ISR_FLOW  = 6'h20;
endpackage : uie_pkg

// ==== uie_src_if.sv ====
// Interface carrying raw interrupt sources from status logic to the encoder.
// Assumes both ends share mclk_i.
`timescale 1ns/100ps
interface uie_src_if;
    logic [7:0] enable;
    logic       fifo_on;
    logic       line_err;
    logic       rx_tmo;
    logic       rx_rdy;
    logic       tx_rdy;
    logic       modem;
    logic       pause;
    logic       flow;
    modport src (output enable, fifo_on, line_err, rx_tmo, rx_rdy, tx_rdy, modem, pause, flow);
    modport dst (input enable, fifo_on, line_err, rx_tmo, rx_rdy, tx_rdy, modem, pause, flow);
endinterface : uie_src_if

// ==== uie_irq_enc.sv ====
// Interrupt encoder: masks sources by the enable bits and picks the highest.
// Assumes sources are levels, registered by the caller.
`timescale 1ns/100ps
module uie_irq_enc (
    uie_src_if.dst    s,        // Raw sources and enables
    output logic [7:0] isr_o,   // Status value
    output logic       pend_o   // Any enabled source pending
);
    logic [7:0] en;
    assign en = s.enable;
    always_comb begin
        pend_o = 1'b1;
        if (en[uie_pkg::IE_LINE] && s.line_err)                // R1 R14 R17
            isr_o = {2'b00, uie_pkg::ISR_LINE};
        else if (en[uie_pkg::IE_RX] && s.rx_tmo)
            isr_o = {2'b00, uie_pkg::ISR_RXTO};
        else if (en[uie_pkg::IE_RX] && s.rx_rdy)               // R2 R3 R11
            isr_o = {2'b00, uie_pkg::ISR_RXRDY};
        else if (en[uie_pkg::IE_TX] && s.tx_rdy)               // R12 R13
            isr_o = {2'b00, uie_pkg::ISR_TXRDY};
        else if (en[uie_pkg::IE_MODEM] && s.modem)             // R18
            isr_o = {2'b00, uie_pkg::ISR_MODEM};
        else if (en[uie_pkg::IE_PAUSE] && s.pause)             // R20
            isr_o = {2'b00, uie_pkg::ISR_PAUSE};
        else if (en[uie_pkg::IE_RTS] && s.flow)                // R21
            isr_o = {2'b00, uie_pkg::ISR_FLOW};
        else begin
            isr_o  = uie_pkg::ISR_NONE;                        // R22
            pend_o = 1'b0;
        end
        if (pend_o)
            isr_o[7:6] = {2{s.fifo_on}};
        else
            isr_o[7:6] = {2{s.fifo_on}};
    end
endmodule : uie_irq_enc

// ==== uie_rx_level.sv ====
// Receive trigger comparator: fill at or above trigger level.
// Assumes fill and trigger are in characters, same width.
`timescale 1ns/100ps
module uie_rx_level #(
    parameter int W = 7
) (
    input  wire logic [W-1:0] fill_i,   // Receive FIFO fill
    input  wire logic [W-1:0] trig_i,   // Programmed trigger level
    input  wire logic         fifo_i,   // FIFO mode
    input  wire logic         hold_i,   // Holding register full (non-FIFO)
    output logic              rdy_o     // Receive data ready source
);
    // In FIFO mode raise at trigger, drop below it
    assign rdy_o = fifo_i ? (fill_i >= trig_i) && (fill_i != '0) : hold_i; // R2 R3 R11
endmodule : uie_rx_level

// ==== uie_core.sv ====
// Interrupt enable, status and receive line status logic of one UART channel.
// Assumes a host register port (from an I2C or SPI slave) giving one-cycle
// read/write strobes, and receive/transmit datapath status as synchronous levels.
// How it works
// R1: Enable register masks rx ready, tx empty, line and modem sources
// R2: FIFO mode rx interrupt rises at trigger level, drops below it
// R3: Status shows rx trigger source; both clear below trigger level
// R4: Data ready sets on character into FIFO, clears only when empty
// R5: FIFOs on and enable bits 0..3 clear selects polled mode
// R6: Line status bit 1 flags receive overrun
// R7: Line status bits 2..4 give error of character at holding register
// R8: Line status bit 5 set while transmit holding is empty
// R9: Line status bit 6 set only while transmit FIFO and shift empty
// R10: Line status bit 7 set while any FIFO character has error or break
// R11: Rx ready fires on holding data, or trigger level in FIFO mode
// R12: Tx ready fires on holding empty, or spaces above trigger in FIFO
// R13: Setting tx enable with holding empty raises tx ready at once
// R14: Line interrupt when any of status bits 1,2,3,4,7 set
// R15: Overrun interrupts on reception, not at FIFO output
// R16: Error bits track character at FIFO output
// R17: Line interrupt stays while global error bit is set
// R18: Modem status enable gates modem interrupt, resets disabled
// R19: Sleep enable bit writable only with enhanced enable set
// R20: Pause character interrupt enable needs enhanced enable
// R21: Output flow pin rising interrupt enable needs enhanced enable
// R22: Status bit 0 reads 0 while pending, 1 when none
// R23: Interrupt output active while any enabled source pending
`timescale 1ns/100ps
module uie_core #(
    parameter int FILL_W = 7                 // Fill count width for 64 entries
) (
    input  wire logic              mclk_i,          // Clock
    input  wire logic              rst_i,           // Async reset, high
    input  wire logic [3:0]        addr_i,          // Register address
    input  wire logic              wr_i,            // Write strobe
    input  wire logic              rd_i,            // Read strobe
    input  wire logic [7:0]        wdata_i,         // Write data
    input  wire logic [7:0]        enh_ctrl_i,      // Enhanced feature control value
    input  wire logic [FILL_W-1:0] rx_fill_i,       // Receive FIFO fill
    input  wire logic [FILL_W-1:0] rx_trig_i,       // Receive trigger level
    input  wire logic [FILL_W-1:0] tx_space_i,      // Transmit FIFO free spaces
    input  wire logic [FILL_W-1:0] tx_trig_i,       // Transmit trigger in spaces
    input  wire logic              rx_push_i,       // Character into receive FIFO
    input  wire logic              rx_overrun_i,    // Character lost on reception
    input  wire logic [2:0]        rx_head_err_i,   // Break, framing, parity at output
    input  wire logic              rx_any_err_i,    // Errored character in FIFO
    input  wire logic              rx_timeout_i,    // Receive timeout level
    input  wire logic              tx_hold_empty_i, // Transmit holding empty
    input  wire logic              tx_shift_empty_i,// Transmit shift empty
    input  wire logic              modem_i,         // Modem status change level
    input  wire logic              pause_i,         // Pause character seen level
    input  wire logic              rts_rise_i,      // Flow output rise level
    output logic [7:0]             rdata_o,         // Read data
    output logic                   irq_o,           // Interrupt, high active
    output logic                   polled_o,        // Polled FIFO mode
    output logic                   sleep_en_o,      // Sleep mode enable
    output logic [7:0]             line_status_o    // Line status value
);
    logic [7:0] interrupt_enable_reg;
    logic [7:0] line_control_reg;
    logic       fifo_en_reg;
    logic       rx_ready_reg;
    logic       overrun_reg;
    logic       tx_arm_reg;
    logic [7:0] isr_val;
    logic       pend;
    logic       rx_src;
    logic       enh;
    logic       wr_ie;
    logic       rd_isr;
    logic       rd_lsr;
    logic       tx_src;
    logic       tx_src_q;
    logic [7:0] line_status;
    uie_src_if  srcs ();

    assign enh    = enh_ctrl_i[uie_pkg::EFC_ENH];
    assign wr_ie  = wr_i && addr_i == uie_pkg::ADDR_INT_ENABLE && !line_control_reg[uie_pkg::LC_DIV];
    assign rd_isr = rd_i && addr_i == uie_pkg::ADDR_INT_STATUS && !line_control_reg[uie_pkg::LC_DIV];
    assign rd_lsr = rd_i && addr_i == uie_pkg::ADDR_LINE_STATUS;

    // Upper enable bits keep their value when the enhanced bit is off
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            interrupt_enable_reg <= uie_pkg::RST_INT_ENABLE;            // R11 R12 R14 R18
        else if (wr_ie) begin
            interrupt_enable_reg[3:0] <= wdata_i[3:0];
            if (enh)
                interrupt_enable_reg[7:4] <= wdata_i[7:4];              // R19 R20 R21
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            line_control_reg <= uie_pkg::RST_LINE_CTRL;
        else if (wr_i && addr_i == uie_pkg::ADDR_LINE_CTRL)
            line_control_reg <= wdata_i;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            fifo_en_reg <= 1'b0;
        else if (wr_i && addr_i == uie_pkg::ADDR_FIFO_CTRL && line_control_reg != uie_pkg::LINE_CTRL_ENH
                 && !line_control_reg[uie_pkg::LC_DIV])
            fifo_en_reg <= wdata_i[uie_pkg::FC_EN];
    end

    // Data ready: push sets, empty clears; push wins over the clear
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            rx_ready_reg <= 1'b0;
        else if (rx_push_i)
            rx_ready_reg <= 1'b1;                                       // R4
        else if (rx_fill_i == '0)
            rx_ready_reg <= 1'b0;                                       // R4
    end

    // Overrun is sticky until the status is read; a new overrun wins
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            overrun_reg <= 1'b0;
        else if (rx_overrun_i)
            overrun_reg <= 1'b1;                                        // R6 R15
        else if (rd_lsr)
            overrun_reg <= 1'b0;
    end

    // Starts high so the empty holding register after reset is not an edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            tx_src_q <= 1'b1;
        else
            tx_src_q <= tx_src;
    end

    // Tx ready is armed when the empty condition appears or on enable write,
    // cleared by reading status; arming on the edge keeps a steady empty
    // holding register from re-raising it after every status read
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            tx_arm_reg <= 1'b0;
        else if (wr_ie && wdata_i[uie_pkg::IE_TX] && tx_hold_empty_i)
            tx_arm_reg <= 1'b1;                                         // R13
        else if (tx_src && !tx_src_q)
            tx_arm_reg <= 1'b1;                                         // R12
        else if (rd_isr || wr_i && addr_i == 4'h0 && !line_control_reg[uie_pkg::LC_DIV])
            tx_arm_reg <= 1'b0;
    end

    assign tx_src = fifo_en_reg ? (tx_space_i > tx_trig_i) || tx_shift_empty_i && tx_hold_empty_i
                                : tx_hold_empty_i;                      // R12

    always_comb begin
        line_status    = 8'h00;
        line_status[0] = rx_ready_reg;                                  // R4
        line_status[1] = overrun_reg;                                   // R6
        line_status[4:2] = rx_head_err_i;                               // R7 R16
        line_status[5] = tx_hold_empty_i;                               // R8
        line_status[6] = tx_hold_empty_i && tx_shift_empty_i;           // R9
        line_status[7] = rx_any_err_i;                                  // R10
    end

    uie_rx_level #(
        .W      (FILL_W)
    ) u_level (
        .fill_i (rx_fill_i),
        .trig_i (rx_trig_i),
        .fifo_i (fifo_en_reg),
        .hold_i (rx_ready_reg),
        .rdy_o  (rx_src)
    );

    assign srcs.enable   = interrupt_enable_reg;                        // R1
    assign srcs.fifo_on  = fifo_en_reg;
    assign srcs.line_err = |{line_status[7], line_status[4:1]};         // R14 R17
    assign srcs.rx_tmo   = rx_timeout_i && fifo_en_reg;
    assign srcs.rx_rdy   = rx_src;
    assign srcs.tx_rdy   = tx_arm_reg;
    assign srcs.modem    = modem_i;
    assign srcs.pause    = pause_i && enh;
    assign srcs.flow     = rts_rise_i && enh;

    uie_irq_enc u_enc (
        .s      (srcs),
        .isr_o  (isr_val),
        .pend_o (pend)
    );

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= pend;                                              // R23
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            polled_o <= 1'b0;
        else
            polled_o <= fifo_en_reg && interrupt_enable_reg[3:0] == 4'h0; // R5
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_en_o    <= 1'b0;
            line_status_o <= 8'h60;
        end else begin
            sleep_en_o    <= interrupt_enable_reg[uie_pkg::IE_SLEEP];   // R19
            line_status_o <= line_status;
        end
    end

    // Read data is registered: valid the cycle after the read strobe
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            rdata_o <= 8'h00;
        else if (rd_i) begin
            case (addr_i)
                uie_pkg::ADDR_INT_ENABLE:  rdata_o <= interrupt_enable_reg;
                uie_pkg::ADDR_INT_STATUS:  rdata_o <= isr_val;          // R3 R22
                uie_pkg::ADDR_LINE_CTRL:   rdata_o <= line_control_reg;
                uie_pkg::ADDR_LINE_STATUS: rdata_o <= line_status;
                default:                   rdata_o <= 8'h00;
            endcase
        end
    end

    a_irq_follows_pend: assert property (@(posedge mclk_i) disable iff (rst_i)
        pend |=> irq_o) else $error("irq not raised after pending source"); // R23
    a_none_reads_one: assert property (@(posedge mclk_i) disable iff (rst_i)
        !pend |-> isr_val[0]) else $error("status bit 0 low with nothing pending"); // R22
    a_rx_trig_level: assert property (@(posedge mclk_i) disable iff (rst_i)
        fifo_en_reg && rx_fill_i >= rx_trig_i && rx_fill_i != '0 |-> rx_src) else $error("rx trigger missed"); // R2
    a_rx_below_drop: assert property (@(posedge mclk_i) disable iff (rst_i)
        fifo_en_reg && rx_fill_i < rx_trig_i |-> !rx_src) else $error("rx source above trigger only"); // R3
    a_push_sets_ready: assert property (@(posedge mclk_i) disable iff (rst_i)
        rx_push_i |=> line_status[0]) else $error("data ready not set on push"); // R4
    a_overrun_sticks: assert property (@(posedge mclk_i) disable iff (rst_i)
        rx_overrun_i |=> overrun_reg) else $error("overrun not flagged"); // R15
    a_tx_enable_kick: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_ie && wdata_i[1] && tx_hold_empty_i |=> tx_arm_reg) else $error("tx ready not raised"); // R13
    a_line_irq_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        interrupt_enable_reg[2] && rx_any_err_i |=> irq_o) else $error("line irq dropped"); // R17
    a_enh_guard_ie: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_ie && !enh |=> $stable(interrupt_enable_reg[7:4])) else $error("upper enables written"); // R19
endmodule : uie_core

// ==== uie_host_model.sv ====
// Host side of the register port: one-cycle write and read strobes.
// Assumes callers enter its tasks at a falling edge of mclk_i.
`timescale 1ns/100ps
module uie_host_model (
    input  wire logic  mclk_i,   // Clock
    output logic [3:0] addr_o,   // Register address
    output logic       wr_o,     // Write strobe
    output logic       rd_o,     // Read strobe
    output logic [7:0] wdata_o,  // Write data
    output logic [7:0] enh_o     // Enhanced feature control value
);
    initial begin
        addr_o  = 4'h0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
        enh_o   = 8'h00;
    end
    // Idle address and data are inverted so a stale value never looks live
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_o  = a;
        wdata_o = d;
        wr_o    = 1'b1;
        @(negedge mclk_i);
        wr_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
        // One idle cycle so a following call never re-raises a strobe at once
        @(negedge mclk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        addr_o = a;
        rd_o   = 1'b1;
        @(negedge mclk_i);
        rd_o   = 1'b0;
        addr_o = ~a;
        @(negedge mclk_i);
    endtask : rd
    // Upper enable bits are meant to be written only after this is set
    task automatic set_enh(input logic [7:0] v);
        enh_o = v;
    endtask : set_enh
endmodule : uie_host_model

// ==== uie_core_bench.sv ====
// Self-checking bench for uie_core; the driver queues notes, a monitor compares.
// Assumes registered outputs, so notes made at a falling edge are checked at the next rising edge.
`timescale 1ns/100ps
module uie_core_bench;
    typedef struct {
        int         kind;
        logic [7:0] exp;
    } uie_note_s;
    localparam int K_RD = 0, K_LS = 1, K_IRQ = 2, K_POLL = 3, K_SLP = 4;
    logic       mclk_i = 1'b0;
    logic       rst_i  = 1'b1;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, enh_ctrl_i, rdata_o, line_status_o;
    logic [6:0] rx_fill_i, rx_trig_i, tx_space_i, tx_trig_i;
    logic [2:0] rx_head_err_i;
    logic       wr_i, rd_i, rx_push_i, rx_overrun_i, rx_any_err_i, rx_timeout_i, tx_hold_empty_i;
    logic       tx_shift_empty_i, modem_i, pause_i, rts_rise_i, irq_o, polled_o, sleep_en_o, dr, ovr;
    int         n_fail = 0, checks_done = 0;
    uie_note_s  notes[$];
    uie_note_s  cur;
    always #5 mclk_i = ~mclk_i;
    uie_host_model host (.mclk_i(mclk_i), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i),
        .enh_o(enh_ctrl_i));
    uie_core dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
        .enh_ctrl_i(enh_ctrl_i), .rx_fill_i(rx_fill_i), .rx_trig_i(rx_trig_i), .tx_space_i(tx_space_i),
        .tx_trig_i(tx_trig_i), .rx_push_i(rx_push_i), .rx_overrun_i(rx_overrun_i),
        .rx_head_err_i(rx_head_err_i), .rx_any_err_i(rx_any_err_i), .rx_timeout_i(rx_timeout_i),
        .tx_hold_empty_i(tx_hold_empty_i), .tx_shift_empty_i(tx_shift_empty_i), .modem_i(modem_i),
        .pause_i(pause_i), .rts_rise_i(rts_rise_i), .rdata_o(rdata_o), .irq_o(irq_o), .polled_o(polled_o),
        .sleep_en_o(sleep_en_o), .line_status_o(line_status_o));
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] a);
        checks_done++;
        if (a !== e) begin
            n_fail++;
            $display("ERROR %0t: byte %h, expected %h", $time, a, e);
        end
    endtask : cmp_byte
    task automatic cmp_flag(input logic e, input logic a);
        checks_done++;
        if (a !== e) begin
            n_fail++;
            $display("ERROR %0t: flag %b, expected %b", $time, a, e);
        end
    endtask : cmp_flag
    always @(posedge mclk_i) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            case (cur.kind)
                K_RD:    cmp_byte(cur.exp, rdata_o);
                K_LS:    cmp_byte(cur.exp, line_status_o);
                K_IRQ:   cmp_flag(cur.exp[0], irq_o);
                K_POLL:  cmp_flag(cur.exp[0], polled_o);
                default: cmp_flag(cur.exp[0], sleep_en_o);
            endcase
        end
    end
    task automatic note(input int k, input logic [7:0] e);
        notes.push_back('{k, e});
    endtask : note
    function automatic logic [7:0] ls_now();
        return {rx_any_err_i, tx_hold_empty_i & tx_shift_empty_i, tx_hold_empty_i, rx_head_err_i, ovr, dr};
    endfunction : ls_now
    task automatic irq_is(input logic b, input int wait_n);
        repeat (wait_n) @(negedge mclk_i);
        note(K_IRQ, {7'h00, b});
    endtask : irq_is
    task automatic rdx(input logic [3:0] a, input logic [7:0] e);
        host.rd(a);
        note(K_RD, e);
    endtask : rdx
    task automatic done_test(input string s);
        $display("test %s done", s);
    endtask : done_test
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        #100us;
        n_fail++;
        $display("ERROR %0t: watchdog expired", $time);
        final_report();
    end
    initial begin
        {rx_fill_i, rx_trig_i, tx_space_i, tx_trig_i} = 28'h000_0000;
        {rx_push_i, rx_overrun_i, rx_head_err_i, rx_any_err_i, rx_timeout_i} = 7'h00;
        {modem_i, pause_i, rts_rise_i, dr, ovr} = 5'h00;
        {tx_hold_empty_i, tx_shift_empty_i} = 2'h3;
        void'($urandom(12));
        repeat (8) @(negedge mclk_i);
        rst_i = 1'b0;
        rdx(uie_pkg::ADDR_INT_ENABLE, uie_pkg::RST_INT_ENABLE);
        rdx(uie_pkg::ADDR_INT_STATUS, uie_pkg::ISR_NONE);
        note(K_POLL, 8'h00);
        note(K_SLP, 8'h00);
        irq_is(1'b0, 1);
        done_test("reset");
        repeat (8) begin
            {rx_head_err_i, rx_any_err_i, tx_hold_empty_i, tx_shift_empty_i} = 6'($urandom);
            repeat (3) @(negedge mclk_i);
            note(K_LS, ls_now());
        end
        {modem_i, pause_i, rts_rise_i, rx_any_err_i} = 4'hF;
        irq_is(1'b0, 3);
        {modem_i, pause_i, rts_rise_i, rx_any_err_i, rx_head_err_i, tx_shift_empty_i, tx_hold_empty_i} = 9'h003;
        done_test("line status and mask");
        host.wr(uie_pkg::ADDR_INT_ENABLE, 8'h02);
        irq_is(1'b1, 3);
        rdx(uie_pkg::ADDR_INT_STATUS, {2'b00, uie_pkg::ISR_TXRDY});
        irq_is(1'b0, 3);
        done_test("transmit ready");
        host.wr(uie_pkg::ADDR_INT_ENABLE, 8'h04);
        rx_overrun_i = 1'b1;
        @(negedge mclk_i);
        rx_overrun_i = 1'b0;
        ovr = 1'b1;
        irq_is(1'b1, 2);
        rdx(uie_pkg::ADDR_INT_STATUS, {2'b00, uie_pkg::ISR_LINE});
        rdx(uie_pkg::ADDR_LINE_STATUS, ls_now());
        ovr = 1'b0;
        irq_is(1'b0, 3);
        rx_any_err_i = 1'b1;
        irq_is(1'b1, 3);
        note(K_LS, ls_now());
        irq_is(1'b1, 6);
        rx_any_err_i = 1'b0;
        irq_is(1'b0, 3);
        done_test("overrun and error");
        host.wr(uie_pkg::ADDR_LINE_CTRL, 8'h80);
        host.wr(uie_pkg::ADDR_INT_ENABLE, 8'h0F);
        rdx(uie_pkg::ADDR_LINE_CTRL, 8'h80);
        host.wr(uie_pkg::ADDR_LINE_CTRL, 8'h00);
        rdx(uie_pkg::ADDR_INT_ENABLE, 8'h04);
        rdx(4'hF, 8'h00);
        done_test("refusals");
        host.wr(uie_pkg::ADDR_FIFO_CTRL, 8'h01);
        {rx_trig_i, rx_fill_i} = {7'h04, 7'h03};
        rx_push_i = 1'b1;
        @(negedge mclk_i);
        rx_push_i = 1'b0;
        dr = 1'b1;
        host.wr(uie_pkg::ADDR_INT_ENABLE, 8'h01);
        irq_is(1'b0, 3);
        note(K_LS, ls_now());
        rx_fill_i = 7'h04;
        irq_is(1'b1, 3);
        rdx(uie_pkg::ADDR_INT_STATUS, {2'b11, uie_pkg::ISR_RXRDY});
        rx_fill_i = 7'h03;
        irq_is(1'b0, 3);
        rdx(uie_pkg::ADDR_INT_STATUS, 8'hC1);
        rx_fill_i = 7'h00;
        dr = 1'b0;
        repeat (3) @(negedge mclk_i);
        note(K_LS, ls_now());
        done_test("fifo receive");
        host.wr(uie_pkg::ADDR_INT_ENABLE, 8'h00);
        repeat (2) @(negedge mclk_i);
        note(K_POLL, 8'h01);
        host.wr(uie_pkg::ADDR_INT_ENABLE, 8'h08);
        modem_i = 1'b1;
        irq_is(1'b1, 3);
        note(K_POLL, 8'h00);
        rdx(uie_pkg::ADDR_INT_STATUS, {2'b11, uie_pkg::ISR_MODEM});
        modem_i = 1'b0;
        done_test("polled and modem");
        host.wr(uie_pkg::ADDR_INT_ENABLE, 8'hF0);
        rdx(uie_pkg::ADDR_INT_ENABLE, 8'h00);
        host.set_enh(8'h10);
        host.wr(uie_pkg::ADDR_INT_ENABLE, 8'h70);
        rdx(uie_pkg::ADDR_INT_ENABLE, 8'h70);
        note(K_SLP, 8'h01);
        pause_i = 1'b1;
        irq_is(1'b1, 3);
        rdx(uie_pkg::ADDR_INT_STATUS, {2'b11, uie_pkg::ISR_PAUSE});
        pause_i = 1'b0;
        rts_rise_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        rdx(uie_pkg::ADDR_INT_STATUS, {2'b11, uie_pkg::ISR_FLOW});
        rts_rise_i = 1'b0;
        irq_is(1'b0, 3);
        done_test("enhanced enables");
        @(negedge mclk_i);
        final_report();
    end
endmodule : uie_core_bench
